// *** rtl/block_consts.svh ***
// Purpose: offsets, field positions and reset values of the logic block
// Assumes: byte addresses on a 12-bit APB address
// Notes:   config words are 32 bits, one per aligned address
`ifndef BLOCK_CONSTS_SVH
`define BLOCK_CONSTS_SVH
`define N_INPUTS       26
`define N_TERMS        70
`define N_LOGIC_TERMS  64
`define TERM_OE_BASE   64
`define TERM_ASYNC_CLR 68
`define TERM_ASYNC_SET 69
`define ALLOC_WORD     140
`define MC_CFG_WORD    141
`define CFG_DEPTH      145
`define STATUS_ADDR    12'h300
`define MC_REG_BIT     0
`define MC_INV_BIT     1
`define MC_TTYPE_BIT   2
`define MC_CLK_LSB     3
`define MC_OE_LSB      5
`define MC_LP_BIT      7
`define CFG_RESET      32'h00000000
`endif

// *** rtl/block_pkg.sv ***
// Purpose: shared types of the logic block
// Assumes: nothing
// Notes:   encodings are written out
package block_pkg;
    typedef enum logic [1:0] {APB_IDLE = 2'b00, APB_WAIT = 2'b01, APB_DONE = 2'b10} apb_state_t;
    typedef enum logic [1:0] {OE_OFF = 2'b00, OE_ON = 2'b01, OE_TERM_A = 2'b10, OE_TERM_B = 2'b11} oe_mode_t;
    typedef enum logic [1:0] {STEER_OWN = 2'b00, STEER_DOWN = 2'b01, STEER_UP = 2'b10} steer_t;
endpackage : block_pkg

// *** rtl/cfg_bus_if.sv ***
// Purpose: config store access between block top and store
// Assumes: one clock
// Notes:   read data valid the cycle after rd_en
`timescale 1ns/1ps
interface cfg_bus_if #(parameter int AW = 8);
    logic          wr_en;
    logic          rd_en;
    logic [AW-1:0] addr;
    logic [31:0]   wdata;
    logic [31:0]   rdata;
    modport master (output wr_en, output rd_en, output addr, output wdata, input rdata);
    modport store  (input wr_en, input rd_en, input addr, input wdata, output rdata);
endinterface : cfg_bus_if

// *** rtl/cfg_store.sv ***
// Purpose: configuration word store, all words visible in parallel
// Assumes: addresses past DEPTH are ignored on write, read as zero
// Notes:   read data comes from a register
`include "block_consts.svh"
`timescale 1ns/1ps
module cfg_store #(
    parameter int DEPTH = `CFG_DEPTH,
    parameter int AW    = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    cfg_bus_if.store                 bus,
    output      logic [DEPTH*32-1:0] words
);
    import block_pkg::*;
    logic [31:0] mem_q [DEPTH];
    logic [31:0] mem_d [DEPTH];
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        in_range;

    always_comb begin
        in_range = int'(bus.addr) < DEPTH;
        mem_d    = mem_q;
        rdata_d  = rdata_q;
        if (bus.wr_en && in_range) begin
            mem_d[bus.addr] = bus.wdata;
        end
        if (bus.rd_en) begin
            rdata_d = in_range ? mem_q[bus.addr] : `CFG_RESET;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= `CFG_RESET;
            end
            rdata_q <= `CFG_RESET;
        end else begin
            mem_q   <= mem_d;
            rdata_q <= rdata_d;
        end
    end

    assign bus.rdata = rdata_q;
    for (genvar i = 0; i < DEPTH; i++) begin : g_flat
        assign words[i*32 +: 32] = mem_q[i];
    end
endmodule : cfg_store

// *** rtl/macrocell.sv ***
// Purpose: one macrocell with its output driver control
// Assumes: sum, clears and clock edges already on pclk
// Notes:   pin path delay grows by one cycle in low power
`include "block_consts.svh"
`timescale 1ns/1ps
module macrocell (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               sum,
    input  wire logic [7:0]         cfg,
    input  wire logic [3:0]         clk_rise,
    input  wire logic               async_clr,
    input  wire logic               async_set,
    input  wire logic               oe_a,
    input  wire logic               oe_b,
    output      logic               pin_q,
    output      logic               oe_q,
    output      logic               fb_q
);
    import block_pkg::*;
    logic     state_q, state_d;
    logic     slow_q, pin_d, oe_d, out_d;
    oe_mode_t oe_mode;

    always_comb begin
        oe_mode = oe_mode_t'(cfg[`MC_OE_LSB +: 2]);
        state_d = state_q;
        if (async_clr) begin
            state_d = 1'b0; // see RQ9 see RQ10 see RQ19
        end else if (async_set) begin
            state_d = 1'b1; // see RQ9 see RQ10
        end else if (cfg[`MC_REG_BIT] && clk_rise[cfg[`MC_CLK_LSB +: 2]]) begin // see RQ7 see RQ8
            state_d = cfg[`MC_TTYPE_BIT] ? (state_q ^ sum) : sum; // see RQ6 see RQ18
        end
        out_d = cfg[`MC_INV_BIT] ^ (cfg[`MC_REG_BIT] ? state_d : sum); // see RQ4
        pin_d = cfg[`MC_LP_BIT] ? slow_q : out_d; // see RQ15
        case (oe_mode) // see RQ11 see RQ12
            OE_OFF:    oe_d = 1'b0;
            OE_ON:     oe_d = 1'b1;
            OE_TERM_A: oe_d = oe_a;
            OE_TERM_B: oe_d = oe_b;
            default:   oe_d = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= 1'b0;
            slow_q  <= 1'b0;
            pin_q   <= 1'b0;
            oe_q    <= 1'b0;
            fb_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            slow_q  <= out_d;
            pin_q   <= pin_d;
            oe_q    <= oe_d;
            fb_q    <= out_d; // see RQ5
        end
    end
endmodule : macrocell

// *** rtl/term_block.sv ***
// Purpose: product-term logic block with allocator, 16 macrocells and I/O cells
// Assumes: matrix_in is on pclk; pins are asynchronous and synchronised here
// Notes:   configuration is written over APB; feedback is returned registered
// How it works
// RQ1 - 64 logic terms, four per cluster, each cluster steered to exactly one macrocell
// RQ2 - a macrocell sums at most three clusters, so twelve terms
// RQ3 - cluster n reaches macrocells n-1, n, n+1 within its half only
// RQ4 - each macrocell output is registered or combinatorial, true or inverted
// RQ5 - every macrocell returns internal feedback whatever its pin does
// RQ6 - a registered macrocell acts as D or T flip-flop
// RQ7 - each flip-flop picks one of four clock pins; pins also feed data
// RQ8 - apart from clear and set, registers change only on the rising edge of the chosen clock
// RQ9 - one shared clear term and one shared set term, no clock needed
// RQ10 - the shared clear or set acts on all flip-flops at once
// RQ11 - each driver is always on, always off or term controlled
// RQ12 - term controlled drivers pick one of two terms shared by their bank
// RQ13 - four enable terms, two for pins 0-7 and two for pins 8-15
// RQ14 - each input and I/O pin has a weak keeper, never a pull-up
// RQ15 - single paths may be set to low power at one cycle more delay
// RQ16 - the term array is fed from 26 interconnect inputs
// RQ17 - 16 macrocell and 16 pin feedback signals go back to the interconnect
// RQ18 - T mode toggles on a high input and holds on a low one
// RQ19 - clear and set together leave the register cleared
`include "block_consts.svh"
`timescale 1ns/1ps
module term_block #(
    parameter int N_MC   = 16,
    parameter int N_CLK  = 4,
    parameter int ADDR_W = 12
) (
    input  wire logic                           pclk,
    input  wire logic                           presetn,
    input  wire logic [ADDR_W-1:0]              paddr,
    input  wire logic                           psel,
    input  wire logic                           penable,
    input  wire logic                           pwrite,
    input  wire logic [31:0]                    pwdata,
    output      logic [31:0]                    prdata,
    output      logic                           pready,
    output      logic                           pslverr,
    input  wire logic [`N_INPUTS-1:0]           matrix_in,
    input  wire logic [N_CLK-1:0]               clk_pin_in,
    input  wire logic [N_MC-1:0]                io_in,
    output      logic [N_MC-1:0]                io_out,
    output      logic [N_MC-1:0]                io_oe,
    output      logic [N_MC-1:0]                io_hold,
    output      logic [N_CLK-1:0]               clk_pin_hold,
    output      logic [N_CLK-1:0]               clk_pin_data,
    output      logic [N_MC-1:0]                mc_feedback,
    output      logic [N_MC-1:0]                pin_feedback
);
    import block_pkg::*;

    localparam int CW = `CFG_DEPTH * 32;

    // evaluated product term: empty term is off, so unused terms add nothing
    function automatic logic term_hit(input logic [`N_INPUTS-1:0] tmask,
                                      input logic [`N_INPUTS-1:0] cmask,
                                      input logic [`N_INPUTS-1:0] in);
        return (|(tmask | cmask)) && (&(~tmask | in)) && (&(~cmask | ~in));
    endfunction : term_hit

    // target macrocell of a cluster; moves out of the half fall back to own
    function automatic logic [3:0] cluster_dest(input int k, input logic [1:0] code);
        logic [3:0] kk;
        kk = 4'(k);
        if (code == STEER_DOWN && kk[2:0] != 3'h0) begin
            return kk - 4'h1;
        end
        if (code == STEER_UP && kk[2:0] != 3'h7) begin
            return kk + 4'h1;
        end
        return kk;
    endfunction : cluster_dest

    function automatic logic cfg_hit(input logic [ADDR_W-1:0] a);
        return a[1:0] == 2'h0 && int'(a[ADDR_W-1:2]) < `CFG_DEPTH;
    endfunction : cfg_hit

    function automatic logic status_hit(input logic [ADDR_W-1:0] a);
        return a == `STATUS_ADDR;
    endfunction : status_hit

    // pin synchronisers and keepers
    logic [N_MC-1:0]  io_s1_q, io_s1_d;
    logic [N_MC-1:0]  io_s2_q, io_s2_d;
    logic [N_MC-1:0]  io_hold_q, io_hold_d;
    logic [N_CLK-1:0] clk_s1_q, clk_s1_d;
    logic [N_CLK-1:0] clk_s2_q, clk_s2_d;
    logic [N_CLK-1:0] clk_s3_q, clk_s3_d;
    logic [N_CLK-1:0] clk_hold_q, clk_hold_d;
    logic [N_CLK-1:0] clk_rise;

    always_comb begin
        io_s1_d    = io_in;
        io_s2_d    = io_s1_q;
        clk_s1_d   = clk_pin_in;
        clk_s2_d   = clk_s1_q;
        clk_s3_d   = clk_s2_q;
        // keeper follows the settled level; when nobody drives, it re-drives it
        io_hold_d  = io_s2_q; // see RQ14
        clk_hold_d = clk_s2_q; // see RQ14
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            io_s1_q    <= '0;
            io_s2_q    <= '0;
            io_hold_q  <= '0;
            clk_s1_q   <= '0;
            clk_s2_q   <= '0;
            clk_s3_q   <= '0;
            clk_hold_q <= '0;
        end else begin
            io_s1_q    <= io_s1_d;
            io_s2_q    <= io_s2_d;
            io_hold_q  <= io_hold_d;
            clk_s1_q   <= clk_s1_d;
            clk_s2_q   <= clk_s2_d;
            clk_s3_q   <= clk_s3_d;
            clk_hold_q <= clk_hold_d;
        end
    end

    // low-to-high transition seen on the settled clock pin
    assign clk_rise     = clk_s2_q & ~clk_s3_q; // see RQ8
    assign io_hold      = io_hold_q;
    assign clk_pin_hold = clk_hold_q;
    assign clk_pin_data = clk_s2_q; // see RQ7
    assign pin_feedback = io_s2_q; // see RQ17

    // configuration store
    cfg_bus_if #(.AW(8)) cfg_bus ();
    logic [CW-1:0] cfg_words;

    cfg_store #(
        .DEPTH (`CFG_DEPTH),
        .AW    (8)
    ) u_store (
        .pclk    (pclk),
        .presetn (presetn),
        .bus     (cfg_bus),
        .words   (cfg_words)
    );

    // product-term array
    logic [`N_TERMS-1:0] term_v;

    for (genvar t = 0; t < `N_TERMS; t++) begin : g_term
        assign term_v[t] = term_hit(cfg_words[(2*t)*32 +: `N_INPUTS],
                                    cfg_words[(2*t+1)*32 +: `N_INPUTS],
                                    matrix_in); // see RQ16
    end

    // logic allocator
    logic [31:0]     alloc_word;
    logic [N_MC-1:0] cluster_or;
    logic [N_MC-1:0] mc_sum;

    assign alloc_word = cfg_words[`ALLOC_WORD*32 +: 32];

    for (genvar k = 0; k < N_MC; k++) begin : g_cluster
        assign cluster_or[k] = |term_v[4*k +: 4]; // see RQ1
    end

    always_comb begin
        mc_sum = '0;
        for (int m = 0; m < N_MC; m++) begin
            for (int k = 0; k < N_MC; k++) begin
                // each cluster matches one macrocell only, never two
                if (cluster_dest(k, alloc_word[2*k +: 2]) == 4'(m)) begin // see RQ1 see RQ3
                    mc_sum[m] = mc_sum[m] | cluster_or[k]; // see RQ2
                end
            end
        end
    end

    // macrocells and I/O cells
    logic async_clr;
    logic async_set;

    assign async_clr = term_v[`TERM_ASYNC_CLR]; // see RQ9 see RQ10
    assign async_set = term_v[`TERM_ASYNC_SET]; // see RQ9 see RQ10

    for (genvar m = 0; m < N_MC; m++) begin : g_mc
        macrocell u_mc (
            .pclk      (pclk),
            .presetn   (presetn),
            .sum       (mc_sum[m]),
            .cfg       (cfg_words[`MC_CFG_WORD*32 + m*8 +: 8]),
            .clk_rise  (clk_rise),
            .async_clr (async_clr),
            .async_set (async_set),
            .oe_a      (term_v[`TERM_OE_BASE + 2*(m/8)]), // see RQ13
            .oe_b      (term_v[`TERM_OE_BASE + 2*(m/8) + 1]), // see RQ13
            .pin_q     (io_out[m]),
            .oe_q      (io_oe[m]),
            .fb_q      (mc_feedback[m]) // see RQ17
        );
    end

    // APB slave: setup, one wait cycle, then pready
    apb_state_t  state_q, state_d;
    logic        pready_q, pready_d;
    logic        pslverr_q, pslverr_d;
    logic [31:0] prdata_q, prdata_d;
    logic [31:0] status_word;
    logic        bad_req;

    assign status_word = {pin_feedback, mc_feedback};

    always_comb begin
        state_d           = state_q;
        pready_d          = 1'b0;
        pslverr_d         = 1'b0;
        prdata_d          = prdata_q;
        cfg_bus.rd_en     = 1'b0;
        cfg_bus.wr_en     = 1'b0;
        cfg_bus.addr      = paddr[9:2];
        cfg_bus.wdata     = pwdata;
        // status is read only; everything else outside the map is an error
        bad_req = !(cfg_hit(paddr) || (status_hit(paddr) && !pwrite));
        case (state_q)
            APB_IDLE: begin
                if (psel && !penable) begin
                    cfg_bus.rd_en = !pwrite;
                    state_d       = APB_WAIT;
                end
            end
            APB_WAIT: begin
                state_d   = APB_DONE;
                pready_d  = 1'b1;
                pslverr_d = bad_req;
                if (pwrite || bad_req) begin
                    prdata_d = 32'h00000000;
                end else if (status_hit(paddr)) begin
                    prdata_d = status_word;
                end else begin
                    prdata_d = cfg_bus.rdata;
                end
            end
            APB_DONE: begin
                state_d = APB_IDLE;
                // write lands on the completing edge only
                cfg_bus.wr_en = psel && penable && pwrite && cfg_hit(paddr);
            end
            default: begin
                state_d = APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q   <= APB_IDLE;
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h00000000;
        end else begin
            state_q   <= state_d;
            pready_q  <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q  <= prdata_d;
        end
    end

    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign prdata  = prdata_q;
endmodule : term_block

// *** sim/board_model.sv ***
// Purpose: board side of the I/O pins
// Assumes: the block's own driver wins over the board
// Notes:   an undriven pin settles at the keeper level
`timescale 1ns/1ps
module board_model (
    input  wire logic [15:0] io_out,
    input  wire logic [15:0] io_oe,
    input  wire logic [15:0] io_hold,
    input  wire logic [15:0] drv,
    input  wire logic [15:0] drv_en,
    output      logic [15:0] io_in
);
    assign io_in = (io_oe & io_out) | (~io_oe & drv_en & drv) | (~io_oe & ~drv_en & io_hold);
endmodule : board_model

// *** sim/term_block_sva.sv ***
// Purpose: port checker for term_block
// Assumes: one wait cycle on every APB access
// Notes:   bound from the bench top
`timescale 1ns/1ps
module term_block_sva #(
    parameter int N_MC   = 16,
    parameter int N_CLK  = 4,
    parameter int ADDR_W = 12
) (
    input wire logic              pclk,
    input wire logic              presetn,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [N_CLK-1:0]  clk_pin_in,
    input wire logic [N_MC-1:0]   io_in,
    input wire logic [N_CLK-1:0]  clk_pin_data,
    input wire logic [N_MC-1:0]   pin_feedback
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_apb_wait: assert property (psel && !penable |=> !pready ##1 pready)
        else $error("ready not after one wait");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_status_ro: assert property (pready && pwrite && paddr == 12'h300 |-> pslverr)
        else $error("status write accepted");
    a_unaligned: assert property (pready && paddr[1:0] != 2'h0 |-> pslverr)
        else $error("unaligned access accepted");
    a_err_data: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read returned data");
    a_pin_sync: assert property ($past(presetn, 2) && $past(presetn) |-> pin_feedback == $past(io_in, 2))
        else $error("pin feedback not two cycles behind");
    a_clk_data: assert property ($past(presetn, 2) && $past(presetn) |-> clk_pin_data == $past(clk_pin_in, 2))
        else $error("clock pin data not two cycles behind");
endmodule : term_block_sva

// *** sim/test_term_block.sv ***
// Purpose: self-checking bench for term_block
// Assumes: configuration only over APB
// Notes:   outputs snapped on the falling edge to dodge edge races
`timescale 1ns/1ps
module test_term_block;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [25:0] matrix_in;
    logic [3:0]  clk_pin_in, clk_pin_data;
    logic [15:0] io_in, io_out, io_oe, io_hold, mc_feedback, pin_feedback, drv, drv_en, s_fb, s_out, s_oe;
    int          failures;
    int          n_checks;
    term_block i_term_block (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .matrix_in(matrix_in), .clk_pin_in(clk_pin_in), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
        .io_hold(io_hold), .clk_pin_hold(), .clk_pin_data(clk_pin_data), .mc_feedback(mc_feedback),
        .pin_feedback(pin_feedback));
    board_model i_board_model (.io_out(io_out), .io_oe(io_oe), .io_hold(io_hold), .drv(drv),
        .drv_en(drv_en), .io_in(io_in));
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    always @(negedge pclk) {s_fb, s_out, s_oe} <= {mc_feedback, io_out, io_oe};
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask : wt
    // request held until the edge that samples pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        wt(1);
        penable <= 1'b1;
        // pready and read data are taken at the rising edge that samples them
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            failures++;
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // one idle cycle so a following call never re-drives psel in this time step
        wt(1);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    // pin held 3 cycles: the synchroniser needs two to see it
    task automatic pulse(input int p);
        clk_pin_in[p] <= 1'b1;
        wt(3);
        clk_pin_in[p] <= 1'b0;
        wt(5);
    endtask : pulse
    task automatic t_bus;
        apb(1'b0, 12'h300, 32'h0);
        chk("status", rd, 32'h00A50000);
        apb(1'b0, 12'h230, 32'h0);
        chk("alloc reset", rd, 32'h0);
        wr(12'h230, 32'h00000004);
        apb(1'b0, 12'h230, 32'h0);
        chk("alloc back", rd, 32'h00000004);
        apb(1'b0, 12'h232, 32'h0);
        chk("unaligned", {31'h0, er}, 32'h1);
        wr(12'h300, 32'hFFFFFFFF);
        chk("status write", {31'h0, er}, 32'h1);
        apb(1'b0, 12'h3FC, 32'h0);
        chk("unmapped", {31'h0, er}, 32'h1);
        $display("t_bus done");
    endtask : t_bus
    task automatic t_comb;
        wr(12'h230, 32'h0);
        wr(12'h000, 32'h02000000);
        wr(12'h234, 32'h00000020);
        matrix_in <= 26'h2000000;
        wt(4);
        chk("comb", {29'h0, s_oe[0], s_out[0], s_fb[0]}, 32'h7);
        wr(12'h234, 32'h00000022);
        wt(3);
        chk("inverted", {29'h0, s_oe[0], s_out[0], s_fb[0]}, 32'h4);
        wr(12'h234, 32'h00000080);
        wt(3);
        chk("buried", {29'h0, s_oe[0], s_out[0], s_fb[0]}, 32'h3);
        matrix_in <= 26'h0;
        wt(2);
        chk("slow path", {29'h0, s_oe[0], s_out[0], s_fb[0]}, 32'h2);
        wt(1);
        chk("slow done", {31'h0, s_out[0]}, 32'h0);
        $display("t_comb done");
    endtask : t_comb
    task automatic t_steer;
        wr(12'h234, 32'h0);
        wr(12'h000, 32'h00000001);
        wr(12'h020, 32'h00000001);
        wr(12'h230, 32'h00000004);
        matrix_in <= 26'h1;
        wt(4);
        chk("steer down", {30'h0, s_fb[1:0]}, 32'h1);
        wr(12'h230, 32'h00000001);
        wt(3);
        chk("edge own", {30'h0, s_fb[1:0]}, 32'h3);
        $display("t_steer done");
    endtask : t_steer
    task automatic t_reg;
        wr(12'h020, 32'h0);
        wr(12'h234, 32'h00000009);
        pulse(0);
        chk("other clock", {31'h0, s_fb[0]}, 32'h0);
        pulse(1);
        chk("d capture", {31'h0, s_fb[0]}, 32'h1);
        wr(12'h234, 32'h0000000D);
        pulse(1);
        chk("toggle low", {31'h0, s_fb[0]}, 32'h0);
        pulse(1);
        chk("toggle high", {31'h0, s_fb[0]}, 32'h1);
        matrix_in <= 26'h4;
        pulse(1);
        chk("t hold", {31'h0, s_fb[0]}, 32'h1);
        wr(12'h220, 32'h00000004);
        wt(3);
        chk("async clear", {31'h0, s_fb[0]}, 32'h0);
        wr(12'h228, 32'h00000004);
        wt(3);
        chk("clear wins", {31'h0, s_fb[0]}, 32'h0);
        wr(12'h220, 32'h0);
        wt(3);
        chk("async set", {31'h0, s_fb[0]}, 32'h1);
        wr(12'h228, 32'h0);
        $display("t_reg done");
    endtask : t_reg
    task automatic t_oe;
        wr(12'h200, 32'h00000008);
        wr(12'h218, 32'h00000010);
        wr(12'h234, 32'h00000040);
        wr(12'h23C, 32'h00000060);
        matrix_in <= 26'h8;
        wt(3);
        chk("bank a", {30'h0, s_oe[8], s_oe[0]}, 32'h1);
        matrix_in <= 26'h10;
        wt(3);
        chk("bank b", {30'h0, s_oe[8], s_oe[0]}, 32'h2);
        $display("t_oe done");
    endtask : t_oe
    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : final_report
    initial begin
        presetn    = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        matrix_in  = 26'h0;
        clk_pin_in = 4'h0;
        drv        = 16'hA5A5;
        drv_en     = 16'h00FF;
        failures   = 0;
        n_checks   = 0;
        wt(10);
        presetn <= 1'b1;
        wt(1);
        t_bus;
        t_comb;
        t_steer;
        t_reg;
        t_oe;
        final_report;
    end
    // whole run is well under 1000 cycles
    initial begin
        wt(20000);
        failures++;
        final_report;
    end
endmodule : test_term_block
bind term_block term_block_sva #(.N_MC(N_MC), .N_CLK(N_CLK), .ADDR_W(ADDR_W)) i_term_block_sva (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_pin_in(clk_pin_in), .io_in(io_in),
    .clk_pin_data(clk_pin_data), .pin_feedback(pin_feedback));
